// File: hw/akd_decoder.sv
`timescale 1ns/100ps
//
// Function
// - Each band of sixteen conversion values maps to one key code 01h up to 0Fh, with only 00h-07h giving key 0.
// - Conversion values F8h to FFh give the no-key code 10h.
// - The code is found by adding 8; a carry gives no-key, else the upper nibble is the key.
// - A code becomes valid only after five equal samples in a row.
// - A differing sample is stored as previous code, the counter reloads to four and done clears.
// - An equal sample while not done decrements the counter and sets done when it hits zero.
// - At done, a debounced code differing from the valid key replaces it and sets the change flag.
// - While done, equal samples change neither counter, valid key nor flags.
// - The change flag is only ever cleared by the consumer or by reset.
// - Reset sets valid and previous codes to no-key, the counter to five and both flags clear.
module akd_decoder #(
	parameter int TIMER_CYC = akd_pkg::TIMER_EVENT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [7:0]  conversion_result,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic [4:0]       valid_key_code,
	output logic             key_change_flag
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic [4:0] decodeKey(input logic [7:0] raw);
		logic [8:0] sum;
		sum = {1'b0, raw} + {1'b0, akd_pkg::DECODE_BIAS};
		if (sum[8]) begin
			decodeKey = akd_pkg::NO_KEY_CODE;
		end else begin
			decodeKey = {1'b0, sum[7:4]};
		end
	endfunction

	// ----------------------------------------
	// Inputs and tick
	// ----------------------------------------
	// Converter result is asynchronous to us; two stages before use
	logic [7:0]        convSync1;
	logic [7:0]        convSync2;
	logic              stepPulse;
	logic              ctrlEnable;
	logic [1:0]        maskReg;
	akd_pkg::akd_state_t st;
	logic [4:0]        sampleKey;
	logic              apbWrite;
	logic              apbRead;
	logic              clearChange;
	logic              setChange;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			convSync1 <= 8'h00;
			convSync2 <= 8'h00;
		end else begin
			convSync1 <= conversion_result;
			convSync2 <= convSync1;
		end
	end

	akd_step_tick #(
		.TIMER_CYC (TIMER_CYC)
	) u_tick (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.enable    (ctrlEnable),
		.stepPulse (stepPulse)
	);

	assign sampleKey = decodeKey(convSync2);

	// ----------------------------------------
	// Debounce
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st.validKey        <= akd_pkg::NO_KEY_CODE;
			st.previousKey     <= akd_pkg::NO_KEY_CODE;
			st.debounceCounter <= akd_pkg::MATCH_COUNT;
			st.debounceDone    <= 1'b0;
		end else if (stepPulse) begin
			if (sampleKey != st.previousKey) begin
				st.previousKey     <= sampleKey;
				st.debounceCounter <= akd_pkg::MATCH_RELOAD;
				st.debounceDone    <= 1'b0;
			end else if (!st.debounceDone) begin
				st.debounceCounter <= st.debounceCounter - 3'h1;
				if (st.debounceCounter == 3'h1) begin
					st.debounceDone <= 1'b1;
					st.validKey     <= st.previousKey;
				end
			end
			// Done and equal: hold everything.
		end
	end

	assign setChange = stepPulse && (sampleKey == st.previousKey) && !st.debounceDone
		&& (st.debounceCounter == 3'h1) && (st.previousKey != st.validKey);

	// ----------------------------------------
	// Change flag, set beats clear
	// ----------------------------------------
	assign apbWrite    = psel && penable && pwrite;
	assign apbRead     = psel && !penable && !pwrite;
	assign clearChange = apbWrite && (paddr == akd_pkg::ADDR_STATUS) && pwdata[akd_pkg::ST_CHANGE_BIT];

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			key_change_flag <= 1'b0;
		end else if (setChange) begin
			key_change_flag <= 1'b1;
		end else if (clearChange) begin
			key_change_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			valid_key_code <= akd_pkg::NO_KEY_CODE;
		end else begin
			valid_key_code <= st.validKey;
		end
	end

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			maskReg    <= akd_pkg::MASK_RESET;
			ctrlEnable <= akd_pkg::CTRL_RESET;
		end else if (apbWrite) begin
			if (paddr == akd_pkg::ADDR_MASK) begin
				maskReg <= pwdata[1:0];
			end
			if (paddr == akd_pkg::ADDR_CTRL) begin
				ctrlEnable <= pwdata[akd_pkg::CTRL_EN_BIT];
			end
		end
	end

	// Read data registered in setup so pready/prdata come from flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (apbRead) begin
				unique case (paddr)
					akd_pkg::ADDR_STATUS: prdata <= {30'h0, st.debounceDone, key_change_flag};
					akd_pkg::ADDR_MASK:   prdata <= {30'h0, maskReg};
					akd_pkg::ADDR_KEY:    prdata <= {27'h0, st.validKey};
					akd_pkg::ADDR_CTRL:   prdata <= {31'h0, ctrlEnable};
					default: begin
						prdata  <= 32'h0;
						pslverr <= 1'b1;
					end
				endcase
			end else if (psel && !penable) begin
				prdata <= 32'h0;
				pslverr <= !((paddr == akd_pkg::ADDR_STATUS) || (paddr == akd_pkg::ADDR_MASK)
					|| (paddr == akd_pkg::ADDR_KEY) || (paddr == akd_pkg::ADDR_CTRL));
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= (key_change_flag && maskReg[akd_pkg::ST_CHANGE_BIT])
				|| (st.debounceDone && maskReg[akd_pkg::ST_DONE_BIT]);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reload_four: assert property (@(posedge clk_sys) disable iff (!rst_b)
		stepPulse && sampleKey != st.previousKey |=> st.debounceCounter == 3'h4 && !st.debounceDone)
		else $error("counter not reloaded to four");
	a_decrement_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
		stepPulse && sampleKey == st.previousKey && !st.debounceDone
		|=> st.debounceCounter == $past(st.debounceCounter) - 3'h1)
		else $error("counter not decremented");
	a_done_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		stepPulse && sampleKey == st.previousKey && st.debounceDone |=> $stable(st))
		else $error("state moved while done");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
		key_change_flag && !clearChange |=> key_change_flag)
		else $error("change flag dropped by itself");
	a_change_sets: assert property (@(posedge clk_sys) disable iff (!rst_b)
		setChange |=> key_change_flag && st.validKey == $past(st.previousKey))
		else $error("change flag or key not updated");
	a_valid_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!stepPulse |=> $stable(st.validKey))
		else $error("valid key changed outside step");
	a_decode_nokey: assert property (@(posedge clk_sys) disable iff (!rst_b)
		convSync2 >= 8'hf8 |-> sampleKey == 5'h10)
		else $error("top band not no-key");
	a_decode_band: assert property (@(posedge clk_sys) disable iff (!rst_b)
		convSync2 < 8'hf8 |-> sampleKey == 5'((convSync2 + 9'h8) >> 4))
		else $error("band decode wrong");
	a_step_spacing: assert property (@(posedge clk_sys) disable iff (!rst_b)
		stepPulse |=> !stepPulse [*2])
		else $error("steps too close");

endmodule

// File: hw/akd_pkg.sv
package akd_pkg;

	// ----------------------------------------
	// Key codes and debounce
	// ----------------------------------------
	localparam logic [4:0] NO_KEY_CODE      = 5'h10;
	localparam logic [7:0] DECODE_BIAS      = 8'h08;
	localparam logic [2:0] MATCH_COUNT      = 3'h5;
	localparam logic [2:0] MATCH_RELOAD     = 3'h4;

	// ----------------------------------------
	// Sample tick
	// ----------------------------------------
	localparam int         CLK_HZ           = 40000000;
	localparam int         TIMER_EVENT_US   = 1950;
	localparam int         TIMER_EVENT_CYC  = (CLK_HZ / 1000) * TIMER_EVENT_US / 1000;
	localparam logic [1:0] EVENTS_PER_STEP  = 2'h3;

	// ----------------------------------------
	// APB map
	// ----------------------------------------
	localparam logic [11:0] ADDR_STATUS     = 12'h000;
	localparam logic [11:0] ADDR_MASK       = 12'h004;
	localparam logic [11:0] ADDR_KEY        = 12'h008;
	localparam logic [11:0] ADDR_CTRL       = 12'h00c;
	localparam int          ST_CHANGE_BIT   = 0;
	localparam int          ST_DONE_BIT     = 1;
	localparam int          CTRL_EN_BIT     = 0;
	localparam logic [1:0]  MASK_RESET      = 2'h0;
	localparam logic        CTRL_RESET      = 1'b1;

	typedef struct packed {
		logic [4:0] validKey;
		logic [4:0] previousKey;
		logic [2:0] debounceCounter;
		logic       debounceDone;
	} akd_state_t;

endpackage

// File: hw/akd_step_tick.sv
`timescale 1ns/100ps
module akd_step_tick #(
	parameter int TIMER_CYC = akd_pkg::TIMER_EVENT_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic enable,
	output logic      stepPulse
);

	// ----------------------------------------
	// Timer event every 1.95 ms, step every third
	// ----------------------------------------
	logic [31:0] timerCount;
	logic [1:0]  eventCount;
	logic        timerEvent;

	assign timerEvent = enable && (timerCount == 32'(TIMER_CYC - 1));

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			timerCount <= 32'h0;
		end else if (!enable || timerEvent) begin
			timerCount <= 32'h0;
		end else begin
			timerCount <= timerCount + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			eventCount <= akd_pkg::EVENTS_PER_STEP;
			stepPulse  <= 1'b0;
		end else begin
			stepPulse <= 1'b0;
			if (timerEvent) begin
				if (eventCount == 2'h1) begin
					eventCount <= akd_pkg::EVENTS_PER_STEP;
					stepPulse  <= 1'b1;
				end else begin
					eventCount <= eventCount - 2'h1;
				end
			end
		end
	end

endmodule

// File: dv/akd_adc_model.sv
`timescale 1ns/100ps
module akd_adc_model #(
	parameter int CONV_CYC = 4
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic [7:0] analogLevel,
	output logic [7:0]      conversion_result
);
	// ----------------------------------------
	// Periodic conversion
	// ----------------------------------------
	// Result holds between conversions, so the decoder may see a stale value for a few cycles
	int convCnt;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			convCnt <= 0;
			conversion_result <= 8'hff;
		end else if (convCnt == CONV_CYC - 1) begin
			convCnt <= 0;
			conversion_result <= analogLevel;
		end else begin
			convCnt <= convCnt + 1;
		end
	end
endmodule

// File: dv/analog_key_decoder_debounce_tb_top.sv
`timescale 1ns/100ps
module analog_key_decoder_debounce_tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  analogLevel = 8'hff;
	logic [7:0]  conversion_result;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        key_change_flag;
	logic [4:0]  valid_key_code;
	logic [31:0] rd;
	logic        err;
	int          failures = 0;
	int          total_checks = 0;

	always #12.5 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	// Short timer event keeps a full debounce near 150 cycles; step every third event
	akd_decoder #(.TIMER_CYC(10)) akd_decoder_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.conversion_result(conversion_result), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .valid_key_code(valid_key_code),
		.key_change_flag(key_change_flag));
	akd_adc_model akd_adc_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .analogLevel(analogLevel),
		.conversion_result(conversion_result));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			failures++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic expectFlag(input int bound);
		int n;
		n = 0;
		while (key_change_flag !== 1'b1 && n < bound) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= bound) begin
			failures++;
			results();
		end
		// Key output is a registered copy of the state, one edge behind the flag
		@(posedge clk_sys);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic resetValues();
		check(valid_key_code, akd_pkg::NO_KEY_CODE, "key after reset");
		check(key_change_flag, 1'b0, "flag after reset");
		apb(1'b0, akd_pkg::ADDR_STATUS, 32'h0);
		check(rd, 32'h0, "status after reset");
		apb(1'b0, akd_pkg::ADDR_KEY, 32'h0);
		check(rd, 32'h10, "key register after reset");
		apb(1'b0, akd_pkg::ADDR_MASK, 32'h0);
		check(rd, akd_pkg::MASK_RESET, "mask after reset");
		apb(1'b0, akd_pkg::ADDR_CTRL, 32'h0);
		check(rd, 32'h1, "control after reset");
	endtask

	// Alternate band edges so both sides of each even-to-odd band boundary of the add-eight decode are hit
	task automatic decodeBands();
		for (int k = 0; k <= 16; k++) begin
			analogLevel <= (k % 2 == 0 && k < 16) ? 8'(k * 16 + 7) : 8'(k * 16 - 8);
			repeat (100) @(posedge clk_sys);
			check(key_change_flag, 1'b0, "change before five samples");
			expectFlag(200);
			check(valid_key_code, 32'(k), "decoded key");
			apb(1'b1, akd_pkg::ADDR_STATUS, 32'h1);
			@(posedge clk_sys);
			check(key_change_flag, 1'b0, "flag after clear");
		end
	endtask

	task automatic glitchAndHold();
		analogLevel <= 8'h47;
		repeat (40) @(posedge clk_sys);
		analogLevel <= 8'hff;
		repeat (300) @(posedge clk_sys);
		check(key_change_flag, 1'b0, "short glitch accepted");
		check(valid_key_code, 32'h10, "key after glitch");
		analogLevel <= 8'h47;
		expectFlag(300);
		repeat (300) @(posedge clk_sys);
		check(key_change_flag, 1'b1, "flag dropped by itself");
		check(valid_key_code, 32'h4, "key while held");
		apb(1'b0, akd_pkg::ADDR_STATUS, 32'h0);
		check(rd, 32'h3, "change and done bits");
	endtask

	task automatic irqPath();
		apb(1'b1, akd_pkg::ADDR_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b1, "irq with flag unmasked");
		apb(1'b1, akd_pkg::ADDR_MASK, 32'h0);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b0, "irq while masked");
		apb(1'b1, akd_pkg::ADDR_MASK, 32'h1);
		apb(1'b1, akd_pkg::ADDR_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b0, "irq after clear");
		check(key_change_flag, 1'b0, "flag after clear");
	endtask

	task automatic busAndEnable();
		apb(1'b0, 12'h010, 32'h0);
		check(rd, 32'h0, "unmapped read data");
		check({31'h0, err}, 32'h1, "unmapped read error");
		apb(1'b1, akd_pkg::ADDR_KEY, 32'h3);
		apb(1'b0, akd_pkg::ADDR_KEY, 32'h0);
		check(rd, 32'h4, "read-only key written");
		apb(1'b1, akd_pkg::ADDR_CTRL, 32'h0);
		analogLevel <= 8'h97;
		repeat (300) @(posedge clk_sys);
		check(key_change_flag, 1'b0, "change with sampling off");
		apb(1'b1, akd_pkg::ADDR_CTRL, 32'h1);
		expectFlag(300);
		check(valid_key_code, 32'h9, "key after enable");
		check(irq, 1'b1, "irq on new key");
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		resetValues();
		decodeBands();
		glitchAndHold();
		irqPath();
		busAndEnable();
		results();
	end
endmodule
